// ===== dv/sfs_ctrl_model.sv
// Controller model driving commands and write data into the SRAM port
`timescale 1ns/1ps
module sfs_ctrl_model (
  input wire logic clk,
  output sfs_pkg::sfs_cmd_s cmd,
  output logic [sfs_pkg::DATA_W-1:0] dq_in,
  output logic clk_qualify_n
);
  import sfs_pkg::*;
  // ==========
  // Idle: deselected, data bus parked low, write strobe and all lane
  // enables high, clock qualified
  initial begin
    cmd = '0;
    cmd.write_n = 1'b1;
    cmd.byte_lane_write_n = 4'hf;
    cmd.chip_sel1_n = 1'b1;
    dq_in = 36'h0;
    clk_qualify_n = 1'b0;
  end
  // One command per edge; a released data bus toggles so stale data never matches
  task automatic step(input logic wr_n, input logic adv, input logic [ADDR_W-1:0] a,
      input logic [LANE_MAX-1:0] ln, input logic [2:0] cs, input logic dv,
      input logic [DATA_W-1:0] d);
    cmd.write_n = wr_n;
    cmd.advance_or_load = adv;
    cmd.addr = a;
    cmd.byte_lane_write_n = ln;
    {cmd.chip_sel1_n, cmd.chip_sel2, cmd.chip_sel3_n} = cs;
    dq_in = dv ? d : ~dq_in;
    @(posedge clk);
    #1;
  endtask
  // Stall with a changed address on the bus, which must be ignored
  task automatic stall(input int n);
    clk_qualify_n = 1'b1;
    cmd.addr = cmd.addr + 20'h1;
    repeat (n) @(posedge clk);
    #1;
    clk_qualify_n = 1'b0;
  endtask
endmodule

// ===== dv/tb_sfs_sram_port.sv
// Self-checking bench for the flow-through burst SRAM port
`timescale 1ns/1ps
module tb_sfs_sram_port;
  import sfs_pkg::*;
  localparam logic [2:0] SEL = 3'h2;
  logic clk, rst_b, out_enable_n, burst_linear, sleep_input, clk_qualify_n, dq_oe, power_down;
  sfs_cmd_s cmd;
  logic [DATA_W-1:0] dq_in, dq_out;
  int fail_count = 0;
  int checks = 0;

  sfs_ctrl_model sfs_ctrl_model_i (.clk(clk), .cmd(cmd), .dq_in(dq_in),
    .clk_qualify_n(clk_qualify_n));
  sfs_sram_port sfs_sram_port_i (.clk(clk), .rst_b(rst_b), .clk_qualify_n(clk_qualify_n),
    .cmd(cmd), .dq_in(dq_in), .out_enable_n(out_enable_n), .burst_linear(burst_linear),
    .sleep_input(sleep_input), .dq_out(dq_out), .dq_oe(dq_oe), .power_down(power_down));

  // ==========
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end

  task automatic give_verdict();
    $display("mismatches %0d checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
      input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // ==========
  // Scenarios
  // Write, overlapping lane write, then read of the same word on the next edge
  task automatic wr_rd();
    sfs_ctrl_model_i.step(1'b0, 1'b0, 20'h10, 4'h0, SEL, 1'b0, '0);
    chk(36'(dq_oe), 36'h0, "driver on in write");
    sfs_ctrl_model_i.step(1'b0, 1'b0, 20'h10, 4'he, SEL, 1'b1, 36'h123456789);
    sfs_ctrl_model_i.step(1'b1, 1'b0, 20'h10, 4'hf, SEL, 1'b1, 36'hfedcba987);
    chk(dq_out, 36'h123456787, "lane merge");
    chk(36'(dq_oe), 36'h1, "driver off in read");
    sfs_ctrl_model_i.stall(3);
    chk(dq_out, 36'h123456787, "stall hold");
    // Read back once the write sits in the array, with no forwarding in play
    sfs_ctrl_model_i.step(1'b1, 1'b0, 20'h10, 4'hf, SEL, 1'b0, '0);
    chk(dq_out, 36'h123456787, "lane merge stored");
  endtask

  // Burst read of the four words at 0x20 from a seed, five steps to see the wrap
  task automatic rd_burst(input logic lin, input logic [1:0] seed);
    logic [1:0] w;
    burst_linear = lin;
    for (int i = 0; i < 5; i++) begin
      w = lin ? seed + 2'(i) : seed ^ 2'(i);
      sfs_ctrl_model_i.step(1'b1, i != 0, {18'h8, seed}, 4'hf, SEL, 1'b0, '0);
      chk(dq_out, 36'h40 + 36'(w), "burst word");
    end
  endtask

  // Linear write burst, partial select, then bursts in both orders
  task automatic bursts();
    burst_linear = 1'b1;
    for (int i = 0; i < 4; i++)
      sfs_ctrl_model_i.step(1'b0, i != 0, 20'h20, 4'h0, SEL, i != 0, 36'h3f + 36'(i));
    sfs_ctrl_model_i.step(1'b1, 1'b0, 20'h0, 4'hf, 3'h3, 1'b1, 36'h43);
    chk({35'h0, power_down}, 36'h1, "partial select awake");
    rd_burst(1'b0, 2'h2);
    rd_burst(1'b1, 2'h3);
  endtask

  // Sleep deselects; output enable acts without a clock edge
  task automatic sleep_oe();
    sleep_input = 1'b1;
    sfs_ctrl_model_i.step(1'b1, 1'b0, 20'h20, 4'hf, SEL, 1'b0, '0);
    chk({35'h0, power_down}, 36'h1, "sleep awake");
    sleep_input = 1'b0;
    sfs_ctrl_model_i.step(1'b1, 1'b0, 20'h21, 4'hf, SEL, 1'b0, '0);
    chk(dq_out, 36'h41, "read after sleep");
    chk({35'h0, power_down}, 36'h0, "asleep in read");
    out_enable_n = 1'b1;
    #1;
    chk(36'(dq_oe), 36'h0, "oe off");
    // The read repeats on the next edge, so drive stays up while enable returns
    @(posedge clk);
    #1;
    out_enable_n = 1'b0;
    #1;
    chk(36'(dq_oe), 36'h1, "oe on");
  endtask

  // ==========
  // Main sequence
  initial begin
    rst_b = 1'b0;
    out_enable_n = 1'b0;
    burst_linear = 1'b1;
    sleep_input = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk({35'h0, power_down}, 36'h1, "reset power state");
    chk(36'(dq_oe), 36'h0, "reset drivers on");
    wr_rd();
    bursts();
    sleep_oe();
    give_verdict();
  end
endmodule

// ===== src/sfs_pkg.sv
// Shared constants and carrier types for the flow-through burst SRAM port
package sfs_pkg;
  // ==========================================================
  // Array geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANE_MAX = 4;
  localparam int LANE_X18 = 2;
  localparam int AW_X36 = 19;
  localparam int AW_X18 = 20;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;

  // ==========================================================
  // Operation state of the current cycle, one-hot
  typedef enum logic [2:0] {
    SFS_IDLE = 3'h1,
    SFS_READ = 3'h2,
    SFS_WRITE = 3'h4
  } sfs_op_e;

  // ==========================================================
  // Synchronous command inputs sampled on each qualified edge
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write_n;
    logic [LANE_MAX-1:0] byte_lane_write_n;
    logic chip_sel1_n;
    logic chip_sel2;
    logic chip_sel3_n;
    logic advance_or_load;
  } sfs_cmd_s;
endpackage

// ===== src/sfs_sram_port.sv
// Flow-through burst SRAM core with registered inputs and self-timed writes
// Behaviour
// - All synchronous inputs and write data are captured on the rising clock edge.
// - With clock-qualify high, edges are ignored and all state holds.
// - Reads and writes follow back to back, one per cycle, no idle cycles.
// - Array is 512K x 36 or 1M x 18 depending on build variant.
// - Write needs write strobe low; only lanes with low lane enables update.
// - Writes complete internally with no extra strobes from the controller.
// - Access selected only when all three chip selects are asserted together.
// - Output enable gates the data drivers asynchronously.
// - Data drivers are off during every write data phase.
// - Driver timing comes from internal state, not from output enable toggling.
// - Read data for an address sampled at an edge appears before the next edge.
// - Burst order is linear or interleaved, chosen by a static input.
// - Low-power state when sleep is asserted or the device is deselected.
// - Advance-or-load high steps the burst counter, low loads a new address.
// - The two low address bits seed the two-bit burst counter.
// - Write strobe sampled only on qualified edges; low writes, high reads.
`timescale 1ns/1ps
module sfs_sram_port #(
  parameter bit WIDE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_qualify_n,
  input wire sfs_pkg::sfs_cmd_s cmd,
  input wire logic [sfs_pkg::DATA_W-1:0] dq_in,
  input wire logic out_enable_n,
  input wire logic burst_linear,
  input wire logic sleep_input,
  output logic [sfs_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic power_down
);
  import sfs_pkg::*;

  // ==========================================================
  // Variant geometry
  localparam int AW = WIDE ? AW_X36 : AW_X18;
  localparam int LN = WIDE ? LANE_MAX : LANE_X18;
  localparam int DW = LN * LANE_W;
  localparam int DEPTH = 1 << AW;

  // Storage declared here; not reset, contents undefined at power-up
  logic [DW-1:0] mem [DEPTH];

  sfs_op_e op;
  sfs_op_e next_op;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [BURST_W-1:0] cnt;
  logic [BURST_W-1:0] next_cnt;
  logic [BURST_W-1:0] next_low;
  logic [AW-1:0] next_word;
  logic [AW-1:0] wr_addr;
  logic [LN-1:0] wr_lanes_n;
  logic wr_pend;
  logic drive;
  logic [DW-1:0] wdata;
  logic [DW-1:0] next_rd;
  logic qual;
  logic selected;

  assign qual = !clk_qualify_n;
  assign selected = !cmd.chip_sel1_n && cmd.chip_sel2 && !cmd.chip_sel3_n;
  assign wdata = dq_in[DW-1:0];

  // ==========================================================
  // Next operation and burst address; sleep forces a deselect
  always_comb begin
    next_op = op;
    next_base = base;
    next_cnt = cnt + BURST_ONE;
    if (sleep_input) begin
      next_op = SFS_IDLE;
    end else if (!cmd.advance_or_load) begin
      next_base = cmd.addr;
      next_cnt = BURST_ZERO;
      if (selected) begin
        next_op = cmd.write_n ? SFS_READ : SFS_WRITE;
      end else begin
        next_op = SFS_IDLE;
      end
    end
  end

  // Linear adds, interleaved XORs; both stay inside the aligned group of four
  assign next_low = burst_linear ? next_base[1:0] + next_cnt : next_base[1:0] ^ next_cnt;
  assign next_word = {next_base[AW-1:BURST_W], next_low};

  // ==========================================================
  // Read word, with the write committing on this same edge forwarded so a
  // write followed at once by a read of that word returns fresh data
  always_comb begin
    next_rd = mem[next_word];
    for (int i = 0; i < LN; i++) begin
      if (wr_pend && wr_addr == next_word && !wr_lanes_n[i]) begin
        next_rd[i*LANE_W +: LANE_W] = wdata[i*LANE_W +: LANE_W];
      end
    end
  end

  // ==========================================================
  // Command state; held whole while the clock is not qualified
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      op <= SFS_IDLE;
      base <= '0;
      cnt <= BURST_ZERO;
    end else if (qual) begin
      op <= next_op;
      base <= next_base;
      cnt <= next_cnt;
    end
  end

  // ==========================================================
  // Self-timed write: data for a write command is taken at the next
  // qualified edge and lands in the array with no further strobes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      wr_lanes_n <= '1;
    end else if (qual) begin
      wr_pend <= (next_op == SFS_WRITE);
      wr_addr <= next_word;
      wr_lanes_n <= cmd.byte_lane_write_n[LN-1:0];
    end
  end

  // Array update, one loop step per byte lane
  always_ff @(posedge clk) begin
    if (rst_b && qual && wr_pend) begin
      for (int i = 0; i < LN; i++) begin
        if (!wr_lanes_n[i]) begin
          mem[wr_addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ==========================================================
  // Read data and internal driver timing; flow-through, so the word is
  // fetched with the sampled address and shows right after the edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dq_out <= '0;
      drive <= 1'b0;
    end else if (qual) begin
      drive <= (next_op == SFS_READ);
      if (next_op == SFS_READ) begin
        dq_out <= DATA_W'(next_rd);
      end
    end
  end

  // Output enable is the one asynchronous term: it gates drivers directly
  assign dq_oe = drive && !out_enable_n;

  // ==========================================================
  // Power-down flag follows sleep or a deselected cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      power_down <= 1'b1;
    end else if (qual) begin
      power_down <= sleep_input || next_op == SFS_IDLE;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_stall_hold;
    clk_qualify_n |=> $stable(op) && $stable(cnt) && $stable(dq_out) && $stable(drive);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("state moved while stalled");

  property p_write_quiet;
    op == SFS_WRITE |-> !dq_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("drivers on in write phase");

  property p_read_drive;
    qual && !sleep_input && !cmd.advance_or_load && selected && cmd.write_n
      |=> op == SFS_READ && drive && dq_oe == !out_enable_n;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read did not drive");

  property p_turn;
    qual && op == SFS_READ && !sleep_input && !cmd.advance_or_load && selected && !cmd.write_n
      |=> op == SFS_WRITE && !drive;
  endproperty
  a_turn: assert property (p_turn) else $error("read to write turn stalled");

  property p_deselect;
    qual && !cmd.advance_or_load && !selected |=> op == SFS_IDLE && power_down;
  endproperty
  a_deselect: assert property (p_deselect) else $error("partial select accepted");

  property p_load_seed;
    qual && !sleep_input && !cmd.advance_or_load |=> cnt == 2'h0 && base == $past(cmd.addr);
  endproperty
  a_load_seed: assert property (p_load_seed) else $error("load did not seed counter");

  property p_advance;
    qual && !sleep_input && cmd.advance_or_load |=> cnt == $past(cnt) + 2'h1 && base == $past(base);
  endproperty
  a_advance: assert property (p_advance) else $error("advance did not step");

  property p_wrap;
    qual && !sleep_input && cmd.advance_or_load && cnt == 2'h3 ##1 1'b1 |-> cnt == 2'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst did not wrap");

  // Judged from the held burst state, so a slip in either order term shows
  property p_order;
    qual && !sleep_input && cmd.advance_or_load
      |-> next_word[AW-1:BURST_W] == base[AW-1:BURST_W]
        && next_word[1:0] == (burst_linear ? base[1:0] + cnt + 2'h1
          : base[1:0] ^ (cnt + 2'h1));
  endproperty
  a_order: assert property (p_order) else $error("burst order wrong");

  property p_sleep;
    qual && sleep_input |=> power_down && op == SFS_IDLE && !dq_oe;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  c_write_read: cover property (op == SFS_WRITE ##1 op == SFS_READ);
  c_burst4: cover property (op == SFS_READ && cnt == 2'h3);
  c_stall: cover property (op == SFS_READ && clk_qualify_n ##1 clk_qualify_n);
  c_sleep: cover property (sleep_input && qual);
endmodule
